// ===== core/llc_pkg.sv
/*
  Shared constants for the line loopback control block: loop control and
  status field positions, indication select codes, persistence timing and
  the automatic loopback state encoding.
  Assumes a single 40 MHz core clock for all users of the package.
*/
package llc_pkg;

  // ----------------------------------------------------------------------
  // Loop control word fields
  // ----------------------------------------------------------------------
  localparam int unsigned LOOP_CTRL_W          = 8;
  localparam int unsigned ANALOG_LOOP_BIT      = 0;
  localparam int unsigned REMOTE_LOOP_BIT      = 1;
  localparam int unsigned DIGITAL_LOOP_BIT     = 2;
  localparam int unsigned AUTO_LOOP_BIT        = 3;
  localparam logic [7:0]  LOOP_CTRL_RESET      = 8'h00;

  // ----------------------------------------------------------------------
  // Status word zero fields
  // ----------------------------------------------------------------------
  localparam int unsigned STATUS_W             = 8;
  localparam int unsigned AUTO_LOOP_STATUS_BIT = 7;
  localparam logic [7:0]  STATUS_RESET         = 8'h00;

  // ----------------------------------------------------------------------
  // Pattern detector side select values
  // ----------------------------------------------------------------------
  localparam logic        SIDE_RECEIVE         = 1'b0;
  localparam logic        SIDE_TRANSMIT        = 1'b1;

  // ----------------------------------------------------------------------
  // Transmit indication select codes
  // ----------------------------------------------------------------------
  localparam int unsigned IND_SEL_W            = 3;
  localparam logic [2:0]  IND_SEL_SYS_BPV      = 3'h5;
  localparam logic [2:0]  IND_SEL_SYS_EXZ_BPV  = 3'h6;
  localparam logic [2:0]  IND_SEL_SYS_LOS      = 3'h7;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam longint unsigned CORE_CLK_HZ        = 64'd40_000_000;
  localparam longint unsigned PERSIST_TIME_MS    = 64'd5100;
  localparam int unsigned     PERSIST_CNT_W      = 28;
  // Least time: round up to whole cycles
  localparam longint unsigned PERSIST_CYCLES_L   = (PERSIST_TIME_MS * CORE_CLK_HZ + 64'd999) / 64'd1000;
  localparam logic [27:0]     PERSIST_CYCLES     = PERSIST_CYCLES_L[27:0];

  // ----------------------------------------------------------------------
  // Automatic loopback states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LLC_AUTO_IDLE    = 2'b00,
    LLC_AUTO_REMOTE  = 2'b01,
    LLC_AUTO_DIGITAL = 2'b10
  } llc_auto_e;

endpackage : llc_pkg

// ===== core/llc_persist_if.sv
/*
  Carrier between the loop controller and one inband code persistence timer.
  Assumes both ends run on the same core clock.
*/
interface llc_persist_if;
  logic code_seen;
  logic expired;

  modport timer (input code_seen, output expired);
  modport owner (output code_seen, input expired);
endinterface : llc_persist_if

// ===== core/llc_persist_timer.sv
/*
  Persistence timer for one inband loop code: pulses expired once when the
  code has been seen without a break for more than the limit.
  Assumes code_seen is synchronous to clk and rst_b is already synchronised.
*/
module llc_persist_timer #(
  parameter logic [27:0] LIMIT_CYCLES = llc_pkg::PERSIST_CYCLES
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Code presence and timeout
  llc_persist_if.timer    persist
);
  import llc_pkg::*;

  if (LIMIT_CYCLES < 28'h0000001) begin : g_bad_limit
    $error("llc_persist_timer: LIMIT_CYCLES must be at least one");
  end

  typedef struct packed {
    logic [PERSIST_CNT_W-1:0] count;
    logic                     done;
    logic                     expired;
  } llc_timer_s;

  llc_timer_s st;
  llc_timer_s next_st;

  always_comb begin
    next_st         = st;
    next_st.expired = 1'b0;
    if (!persist.code_seen) begin
      // Any break in the code starts the wait over
      next_st.count = '0;
      next_st.done  = 1'b0;
    end else if (!st.done) begin
      if (st.count == LIMIT_CYCLES) begin
        // Strictly more than the limit, then one pulse per unbroken run
        next_st.done    = 1'b1;
        next_st.expired = 1'b1;
      end else begin
        next_st.count = st.count + 28'h0000001;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign persist.expired = st.expired;

endmodule : llc_persist_timer

// ===== core/llc_tx_indication.sv
/*
  Transmit multifunction indication selector with the single-rail NRZ
  restriction on the system-side violation and loss indications.
  Assumes all inputs are synchronous to clk and rst_b is synchronised.
*/
module llc_tx_indication (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Selection
  input  wire logic       single_rail_nrz,
  input  wire logic [2:0] select_code,
  input  wire logic [7:0] sources,
  // Indication
  output logic            indication
);
  import llc_pkg::*;

  typedef struct packed {
    logic indication;
  } llc_ind_s;

  llc_ind_s st;
  llc_ind_s next_st;

  function automatic logic nrz_reserved(input logic [2:0] code);
    nrz_reserved = (code == IND_SEL_SYS_BPV) || (code == IND_SEL_SYS_EXZ_BPV) ||
                   (code == IND_SEL_SYS_LOS);
  endfunction : nrz_reserved

  always_comb begin
    next_st = st;
    // Reserved codes hold the pin low rather than show stale data
    if (single_rail_nrz && nrz_reserved(select_code)) begin
      next_st.indication = 1'b0;
    end else begin
      next_st.indication = sources[select_code];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign indication = st.indication;

endmodule : llc_tx_indication

// ===== core/llc_loop_ctrl.sv
/*
  Per-channel loopback controller: analog, remote, digital and dual loopback
  selection, automatic inband loop entry and exit, and data-path steering
  with the diagnostic priorities of each loop mode.
  Assumes every input is synchronous to core_clk (register bits, framer data,
  jitter attenuator and detector outputs); only rst_b is asynchronous.
*/
// Contract
// - Control bit 0 enables analog loopback
// - Analog: transmit data loops into receive input
// - Analog loop masks remote and digital loops
// - Analog: rx pattern first, no AIS
// - Bit 1 or auto enables remote loop
// - Receive-side inband codes drive automatic remote loop
// - Auto enable clear stops; status bit 7
// - Remote: attenuator data to shaper, system ignored
// - Remote: transmit detectors still see system data
// - Remote priorities; transmit AIS disabled
// - Bit 2 or auto enables digital loop
// - Transmit-side inband codes drive automatic digital loop
// - Digital: transmit data into decoder path
// - Digital priorities; receive AIS disabled
// - Dual only manual remote; no auto remote
// - Dual: both directions looped, nothing passes
// - Dual: detector sources per direction
// - Manual dual priorities; AIS off both ways
// - Manual+auto dual: no AIS, no tx pattern
// - NRZ transmit disables marked indications
// - Codes 101, 110, 111 are those indications
module llc_loop_ctrl #(
  parameter logic [27:0] PERSIST_LIMIT = llc_pkg::PERSIST_CYCLES
) (
  // Clock and reset
  input  wire logic                             core_clk,
  input  wire logic                             rst_b,
  // Configuration
  input  wire logic [llc_pkg::LOOP_CTRL_W-1:0]  loop_control,
  input  wire logic                             pattern_detect_side_select,
  input  wire logic                             tx_single_rail_nrz,
  input  wire logic [llc_pkg::IND_SEL_W-1:0]    transmit_indication_select,
  input  wire logic [7:0]                       transmit_indication_sources,
  // Inband loop code detector
  input  wire logic                             inband_activate_seen,
  input  wire logic                             inband_deactivate_seen,
  // Receive side data
  input  wire logic                             line_rx_data,
  input  wire logic                             receive_jitter_attenuator_data,
  input  wire logic                             receive_jitter_attenuator_enable,
  input  wire logic                             rx_pattern_data,
  input  wire logic                             rx_pattern_enable,
  input  wire logic                             rx_ais_request,
  // Transmit side data
  input  wire logic                             system_tx_data,
  input  wire logic                             transmit_jitter_attenuator_data,
  input  wire logic                             tx_pattern_data,
  input  wire logic                             tx_pattern_enable,
  input  wire logic                             tx_ais_request,
  // Steered data
  output logic                                  line_tx_data,
  output logic                                  system_rx_data,
  output logic                                  rx_decoder_data,
  output logic                                  rx_alarm_detect_data,
  output logic                                  tx_detect_data,
  // Status
  output logic [llc_pkg::STATUS_W-1:0]          status_register_zero,
  output logic                                  analog_loop_active,
  output logic                                  remote_loop_active,
  output logic                                  digital_loop_active,
  output logic                                  rx_ais_inserted,
  output logic                                  tx_ais_inserted,
  output logic                                  tx_clock_ignored,
  output logic                                  transmit_multifunction_output
);
  import llc_pkg::*;

  if (PERSIST_LIMIT < 28'h0000001) begin : g_bad_limit
    $error("llc_loop_ctrl: PERSIST_LIMIT must be at least one");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_b;
  logic rst_sync_b;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ----------------------------------------------------------------------
  // Inband persistence timers
  // ----------------------------------------------------------------------
  llc_persist_if activate_if ();
  llc_persist_if deactivate_if ();

  assign activate_if.code_seen   = inband_activate_seen;
  assign deactivate_if.code_seen = inband_deactivate_seen;

  llc_persist_timer #(
    .LIMIT_CYCLES (PERSIST_LIMIT)
  ) u_activate_timer (
    .clk     (core_clk),
    .rst_b   (rst_sync_b),
    .persist (activate_if.timer)
  );

  llc_persist_timer #(
    .LIMIT_CYCLES (PERSIST_LIMIT)
  ) u_deactivate_timer (
    .clk     (core_clk),
    .rst_b   (rst_sync_b),
    .persist (deactivate_if.timer)
  );

  // ----------------------------------------------------------------------
  // Transmit indication pin
  // ----------------------------------------------------------------------
  llc_tx_indication u_tx_indication (
    .clk             (core_clk),
    .rst_b           (rst_sync_b),
    .single_rail_nrz (tx_single_rail_nrz),
    .select_code     (transmit_indication_select),
    .sources         (transmit_indication_sources),
    .indication      (transmit_multifunction_output)
  );

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    llc_auto_e   auto_state;
    logic        line_tx_data;
    logic        system_rx_data;
    logic        rx_decoder_data;
    logic        rx_alarm_detect_data;
    logic        tx_detect_data;
    logic [7:0]  status;
    logic        analog_active;
    logic        remote_active;
    logic        digital_active;
    logic        rx_ais_inserted;
    logic        tx_ais_inserted;
    logic        tx_clock_ignored;
  } llc_ctrl_s;

  llc_ctrl_s st;
  llc_ctrl_s next_st;

  // Three-level priority pick; AIS is all ones on the wire
  function automatic logic pick(input logic hi_en, input logic hi, input logic mid_en,
                                input logic mid, input logic lo);
    if (hi_en) begin
      pick = hi;
    end else if (mid_en) begin
      pick = mid;
    end else begin
      pick = lo;
    end
  endfunction : pick

  logic analog_on;
  logic manual_remote;
  logic manual_digital;
  logic auto_on;
  logic auto_digital;
  logic remote_on;
  logic digital_on;
  logic dual_manual;
  logic dual_auto;
  logic rx_looped_data;
  logic tx_out;
  logic rx_ais_ok;
  logic tx_ais_ok;
  logic tx_pat_ok;

  // ----------------------------------------------------------------------
  // Loop mode decode
  // ----------------------------------------------------------------------
  always_comb begin
    analog_on      = loop_control[ANALOG_LOOP_BIT];
    auto_on        = loop_control[AUTO_LOOP_BIT];
    manual_remote  = loop_control[REMOTE_LOOP_BIT];
    manual_digital = loop_control[DIGITAL_LOOP_BIT];
    auto_digital   = (st.auto_state == LLC_AUTO_DIGITAL);
    // Analog loop wins over everything else
    remote_on      = !analog_on && (manual_remote || (st.auto_state == LLC_AUTO_REMOTE));
    digital_on     = !analog_on && (manual_digital || auto_digital);
    dual_manual    = remote_on && manual_remote && manual_digital;
    dual_auto      = remote_on && manual_remote && auto_digital && !manual_digital;
    // Bypassed attenuator hands over the recovered data
    rx_looped_data = receive_jitter_attenuator_enable ? receive_jitter_attenuator_data : line_rx_data;
  end

  // ----------------------------------------------------------------------
  // Automatic loopback sequencing
  // ----------------------------------------------------------------------
  llc_auto_e next_auto;

  always_comb begin
    next_auto = st.auto_state;
    case (st.auto_state)
      LLC_AUTO_IDLE: begin
        if (auto_on && activate_if.expired) begin
          // Side select is trusted to stay put while a loop is up
          if (pattern_detect_side_select == SIDE_RECEIVE) begin
            // Detector would sit inside a digital loop
            if (!manual_digital) begin
              next_auto = LLC_AUTO_REMOTE;
            end
          end else begin
            next_auto = LLC_AUTO_DIGITAL;
          end
        end
      end
      LLC_AUTO_REMOTE: begin
        if (!auto_on || deactivate_if.expired || manual_digital) begin
          next_auto = LLC_AUTO_IDLE;
        end
      end
      LLC_AUTO_DIGITAL: begin
        if (!auto_on || deactivate_if.expired) begin
          next_auto = LLC_AUTO_IDLE;
        end
      end
      default: begin
        next_auto = LLC_AUTO_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Data steering and diagnostic priorities
  // ----------------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.auto_state = next_auto;
    rx_ais_ok          = 1'b1;
    tx_ais_ok          = 1'b1;
    tx_pat_ok          = 1'b1;

    // Generator permissions per mode
    if (analog_on) begin
      rx_ais_ok = 1'b0;
      tx_ais_ok = 1'b0;
    end else if (dual_manual) begin
      rx_ais_ok = 1'b0;
      tx_ais_ok = 1'b0;
    end else if (dual_auto) begin
      rx_ais_ok = 1'b0;
      tx_ais_ok = 1'b0;
      tx_pat_ok = 1'b0;
    end else begin
      if (remote_on) begin
        tx_ais_ok = 1'b0;
      end
      if (digital_on) begin
        rx_ais_ok = 1'b0;
        // Looped data ranks above AIS, so AIS never reaches the line
        tx_ais_ok = 1'b0;
      end
    end

    // Transmit toward the waveform shaper
    if (dual_manual) begin
      tx_out = rx_looped_data;
    end else if (dual_auto) begin
      tx_out = rx_looped_data;
    end else if (remote_on) begin
      tx_out = pick(tx_pattern_enable, tx_pattern_data, 1'b0, 1'b0, rx_looped_data);
    end else begin
      // Digital and analog loops still drive the line
      tx_out = pick(tx_pattern_enable && tx_pat_ok, tx_pattern_data,
                    tx_ais_request && tx_ais_ok, 1'b1, system_tx_data);
    end
    next_st.line_tx_data = tx_out;

    // Decoder input and receive toward the system side
    if (analog_on) begin
      next_st.rx_decoder_data = tx_out;
      next_st.system_rx_data  = pick(rx_pattern_enable, rx_pattern_data, 1'b0, 1'b0, tx_out);
    end else if (digital_on) begin
      next_st.rx_decoder_data = transmit_jitter_attenuator_data;
      next_st.system_rx_data  = pick(rx_pattern_enable, rx_pattern_data, 1'b0, 1'b0,
                                     transmit_jitter_attenuator_data);
    end else begin
      next_st.rx_decoder_data = line_rx_data;
      // Received data still reaches the system in remote loop
      next_st.system_rx_data  = pick(rx_pattern_enable, rx_pattern_data,
                                     rx_ais_request && rx_ais_ok, 1'b1, line_rx_data);
    end

    // Detector sources
    next_st.rx_alarm_detect_data = analog_on ? tx_out : line_rx_data;
    next_st.tx_detect_data       = system_tx_data;

    // Status
    next_st.status                       = STATUS_RESET;
    next_st.status[AUTO_LOOP_STATUS_BIT] = (next_auto != LLC_AUTO_IDLE);
    next_st.analog_active    = analog_on;
    next_st.remote_active    = remote_on;
    next_st.digital_active   = digital_on;
    next_st.rx_ais_inserted  = !analog_on && !digital_on && !rx_pattern_enable &&
                               rx_ais_request && rx_ais_ok;
    next_st.tx_ais_inserted  = !remote_on && !tx_pattern_enable && tx_ais_request && tx_ais_ok;
    next_st.tx_clock_ignored = remote_on;
  end

  always_ff @(posedge core_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st            <= '0;
      st.auto_state <= LLC_AUTO_IDLE;
      st.status     <= STATUS_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign line_tx_data         = st.line_tx_data;
  assign system_rx_data       = st.system_rx_data;
  assign rx_decoder_data      = st.rx_decoder_data;
  assign rx_alarm_detect_data = st.rx_alarm_detect_data;
  assign tx_detect_data       = st.tx_detect_data;
  assign status_register_zero = st.status;
  assign analog_loop_active   = st.analog_active;
  assign remote_loop_active   = st.remote_active;
  assign digital_loop_active  = st.digital_active;
  assign rx_ais_inserted      = st.rx_ais_inserted;
  assign tx_ais_inserted      = st.tx_ais_inserted;
  assign tx_clock_ignored     = st.tx_clock_ignored;

endmodule : llc_loop_ctrl

// ===== sim/llc_loop_ctrl_asserts.sv
/* Checker for the loopback controller, bound to its top module.
   Assumes one core clock and the asynchronous active-low rst_b. */
module llc_loop_ctrl_asserts #(
  parameter logic [27:0] PERSIST_LIMIT = llc_pkg::PERSIST_CYCLES
) (
  // Clock, reset, configuration, watched inputs (grouped to save space)
  input wire logic       core_clk, rst_b, tx_single_rail_nrz, inband_activate_seen, system_tx_data,
  input wire logic [7:0] loop_control,
  input wire logic [2:0] transmit_indication_select,
  // Watched outputs
  input wire logic       tx_detect_data, analog_loop_active, remote_loop_active, digital_loop_active,
  input wire logic       rx_ais_inserted, tx_ais_inserted, tx_clock_ignored, transmit_multifunction_output,
  input wire logic [7:0] status_register_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  import llc_pkg::*;
  // Outputs follow inputs from the third edge; one edge of margin on top
  logic [2:0]  up;
  logic [27:0] act_run;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      up      <= 3'h0;
      act_run <= 28'h0;
    end else begin
      up      <= (up == 3'h4) ? up : up + 3'h1;
      act_run <= inband_activate_seen ? act_run + 28'h1 : 28'h0;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b || up != 3'h4);
  sequence s_auto_drop;
    loop_control[AUTO_LOOP_BIT] ##1 !loop_control[AUTO_LOOP_BIT];
  endsequence
  sequence s_nrz_blocked;
    tx_single_rail_nrz && (transmit_indication_select >= IND_SEL_SYS_BPV);
  endsequence
  a_analog_masks_loops: assert property (loop_control[0] |=> analog_loop_active && !remote_loop_active
    && !digital_loop_active) else $error("analog loop does not mask the others");
  a_analog_no_ais: assert property (analog_loop_active |-> !rx_ais_inserted && !tx_ais_inserted)
    else $error("AIS driven in analog loop");
  a_remote_manual: assert property (loop_control[2:0] == 3'h2 |=> remote_loop_active && tx_clock_ignored)
    else $error("manual remote loop not taken");
  a_digital_manual: assert property (loop_control[2:0] == 3'h4 |=> digital_loop_active)
    else $error("manual digital loop not taken");
  a_remote_tx_ais: assert property (remote_loop_active |-> !tx_ais_inserted)
    else $error("transmit AIS in remote loop");
  a_digital_rx_ais: assert property (digital_loop_active |-> !rx_ais_inserted)
    else $error("receive AIS in digital loop");
  a_tx_detect_sys: assert property (tx_detect_data == $past(system_tx_data))
    else $error("transmit detectors not on system data");
  a_nrz_reserved: assert property (s_nrz_blocked |=> !transmit_multifunction_output)
    else $error("reserved indication active");
  a_auto_drop: assert property (s_auto_drop |=> !status_register_zero[AUTO_LOOP_STATUS_BIT])
    else $error("auto loop kept after enable cleared");
  a_auto_persist: assert property ($rose(status_register_zero[AUTO_LOOP_STATUS_BIT])
    |-> $past(act_run) > PERSIST_LIMIT) else $error("auto loop entered too early");
endmodule : llc_loop_ctrl_asserts

bind llc_loop_ctrl llc_loop_ctrl_asserts #(.PERSIST_LIMIT(PERSIST_LIMIT)) llc_loop_ctrl_asserts_i (.*);

// ===== sim/llc_framer_model.sv
/* Framer model on the system side: a changing transmit bit stream.
   Assumes the bench clock; the bit moves just after each falling edge. */
module llc_framer_model (
  // Clock
  input  wire logic core_clk,
  // Transmit bit towards the block
  output logic      system_tx_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] prbs = 7'h5A;
  initial system_tx_data = 1'b0;
  always @(negedge core_clk) begin
    prbs           <= {prbs[5:0], prbs[6] ^ prbs[5]};
    system_tx_data <= prbs[6];
  end
endmodule : llc_framer_model

// ===== sim/tb.sv
/* Self-checking bench for the loopback controller with a short persistence.
   Assumes inputs change at falling edges; outputs lag inputs by one edge. */
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import llc_pkg::*;
  localparam int L = 8;
  logic core_clk = 1'b0, rst_b = 1'b0, pattern_detect_side_select, tx_single_rail_nrz;
  logic [7:0] loop_control, transmit_indication_sources, status_register_zero;
  logic [2:0] transmit_indication_select;
  logic inband_activate_seen, inband_deactivate_seen, line_rx_data, receive_jitter_attenuator_data,
        receive_jitter_attenuator_enable, rx_pattern_data, rx_pattern_enable, rx_ais_request, system_tx_data,
        transmit_jitter_attenuator_data, tx_pattern_data, tx_pattern_enable, tx_ais_request, line_tx_data,
        system_rx_data, rx_decoder_data, rx_alarm_detect_data, tx_detect_data, analog_loop_active,
        remote_loop_active, digital_loop_active, rx_ais_inserted, tx_ais_inserted, tx_clock_ignored,
        transmit_multifunction_output;
  logic [31:0] seed = 32'd88975;
  int mismatches = 0, check_count = 0;
  llc_loop_ctrl #(.PERSIST_LIMIT(28'h8)) llc_loop_ctrl_i (.*);
  llc_framer_model llc_framer_model_i (.core_clk, .system_tx_data);
  always #12.5 core_clk = ~core_clk;
  task automatic stop_test();
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic drive_random();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    {line_rx_data, receive_jitter_attenuator_data, receive_jitter_attenuator_enable, rx_pattern_data,
     rx_pattern_enable, rx_ais_request, transmit_jitter_attenuator_data, tx_pattern_data, tx_pattern_enable,
     tx_ais_request, tx_single_rail_nrz, transmit_indication_select, transmit_indication_sources} = seed[21:0];
  endtask : drive_random
  // Expected {line_tx, system_rx, decoder, alarm} for the present inputs
  function automatic logic [3:0] paths(input logic dig);
    logic lt, la, rs, rd;
    lt = tx_pattern_enable ? tx_pattern_data : system_tx_data;
    la = receive_jitter_attenuator_enable ? receive_jitter_attenuator_data : line_rx_data;
    rs = rx_pattern_enable ? rx_pattern_data : (rx_ais_request | line_rx_data);
    rd = rx_pattern_enable ? rx_pattern_data : transmit_jitter_attenuator_data;
    if (loop_control[0]) return {lt, rx_pattern_enable ? rx_pattern_data : lt, lt, lt};
    case ({loop_control[2] | dig, loop_control[1]})
      2'h0: return {tx_pattern_enable ? tx_pattern_data : (tx_ais_request | system_tx_data), rs, line_rx_data,
                    line_rx_data};
      2'h1: return {tx_pattern_enable ? tx_pattern_data : la, rs, line_rx_data, line_rx_data};
      2'h2: return {lt, rd, transmit_jitter_attenuator_data, line_rx_data};
      default: return {la, rd, transmit_jitter_attenuator_data, line_rx_data};
    endcase
  endfunction : paths
  task automatic check_cycle(input logic dig);
    check({4'h0, line_tx_data, system_rx_data, rx_decoder_data, rx_alarm_detect_data}, {4'h0, paths(dig)});
    check({7'h0, transmit_multifunction_output}, {7'h0, (tx_single_rail_nrz && transmit_indication_select >=
      IND_SEL_SYS_BPV) ? 1'b0 : transmit_indication_sources[transmit_indication_select]});
  endtask : check_cycle
  task automatic code_run(input logic act, input logic deact, input int n);
    inband_activate_seen   = act;
    inband_deactivate_seen = deact;
    repeat (n) @(negedge core_clk);
  endtask : code_run
  initial begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    stop_test();
  end
  initial begin
    drive_random();
    {loop_control, pattern_detect_side_select, inband_activate_seen, inband_deactivate_seen} = 11'h0;
    repeat (12) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    repeat (3000) begin
      check_cycle(1'b0);
      drive_random();
      loop_control = {5'h0, seed[24:22]};
      @(negedge core_clk);
    end
    loop_control = 8'h08; // side select held at receive during auto
    code_run(1'b0, 1'b0, 2);
    code_run(1'b1, 1'b0, L);
    code_run(1'b0, 1'b0, 1);
    code_run(1'b1, 1'b0, L + 1);
    check(status_register_zero, 8'h00);
    code_run(1'b1, 1'b0, 1);
    check(status_register_zero, 8'h80);
    code_run(1'b0, 1'b1, 1);
    check({7'h0, remote_loop_active}, 8'h01);
    code_run(1'b0, 1'b1, L);
    check(status_register_zero, 8'h80);
    code_run(1'b0, 1'b1, 1);
    check(status_register_zero, 8'h00);
    code_run(1'b1, 1'b0, L + 3);
    loop_control = 8'h00;
    code_run(1'b1, 1'b0, 1);
    check(status_register_zero, 8'h00);
    code_run(1'b1, 1'b0, L + 4);
    check(status_register_zero, 8'h00);
    loop_control = 8'h0C;
    code_run(1'b0, 1'b0, 1);
    code_run(1'b1, 1'b0, L + 4);
    check({status_register_zero[7], 5'h0, remote_loop_active, digital_loop_active}, 8'h01);
    loop_control = 8'h0A;
    pattern_detect_side_select = 1'b1;
    code_run(1'b0, 1'b0, 1);
    code_run(1'b1, 1'b0, L + 3);
    check(status_register_zero, 8'h80);
    code_run(1'b1, 1'b0, 1);
    check({5'h0, remote_loop_active, digital_loop_active, analog_loop_active}, 8'h06);
    repeat (40) begin
      check_cycle(1'b1);
      drive_random();
      loop_control = {7'h05, seed[22]};
      @(negedge core_clk);
    end
    stop_test();
  end
endmodule : tb
